// *** dif_pkg.sv ***
// Shared constants for the digital input fault and configuration block
package dif_pkg;
   localparam int CLK_NS = 50;
   localparam int TICK_NS = 10000;
   // Filter time base, a least time so it rounds up
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   // Debounce delays in microseconds, code 0 to 7
   localparam int DLY_US [8] = '{50, 100, 400, 800, 1600, 3200, 12800, 20000};
   localparam logic [2:0] WB_CODE = 3'h7;
   localparam int CNT_W = 11;
   localparam int FRAME_CMD = 16;
   localparam int NCH = 8;
   localparam int NASYNC = 27;
   // Register addresses
   localparam logic [6:0] A_WB = 7'h00;
   localparam logic [6:0] A_DI = 7'h02;
   localparam logic [6:0] A_F1 = 7'h04;
   localparam logic [6:0] A_FLT0 = 7'h06;
   localparam logic [6:0] A_FLT7 = 7'h14;
   localparam logic [6:0] A_CFG = 7'h18;
   localparam logic [6:0] A_EN = 7'h1a;
   localparam logic [6:0] A_F2 = 7'h1c;
   localparam logic [6:0] A_F2EN = 7'h1e;
   localparam logic [6:0] A_GPO = 7'h22;
   localparam logic [6:0] A_F1EN = 7'h24;
   localparam logic [6:0] A_NOP = 7'h26;
   // Values after reset, config write mask and primary keep-on-read mask
   localparam logic [4:0] RST_FLT = 5'h08;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_EN = 8'hff;
   localparam logic [5:0] RST_F2 = 6'h02;
   localparam logic [5:0] RST_F2EN = 6'h00;
   localparam logic [7:0] RST_F1EN = 8'hc0;
   localparam logic [7:0] RST_F1 = 8'h46;
   localparam logic [7:0] CFG_WMASK = 8'h19;
   localparam logic [7:0] F1_KEEP_RD = 8'hc1;
   // Field positions
   localparam int FLT_WBE = 4;
   localparam int FLT_BYP = 3;
   localparam int CFG_SUP = 4;
   localparam int CFG_FRZ = 3;
   localparam int CFG_SHE = 0;
   localparam int GPO_STK = 7;
   localparam int F1_CRC = 7;
   localparam int F1_POR = 6;
   localparam int F1_SUM = 5;
   localparam int F1_AT2 = 4;
   localparam int F1_AT1 = 3;
   localparam int F1_SVL = 2;
   localparam int F1_SVM = 1;
   localparam int F1_WBG = 0;
   localparam int F2_CLK = 5;
   localparam int F2_OT = 4;
   localparam int F2_RDO = 3;
   localparam int F2_RDS = 2;
   localparam int F2_RWO = 1;
   localparam int F2_RWS = 0;

   // Filter limit in time base ticks for a delay code
   function automatic logic [CNT_W-1:0] dly_ticks(input logic [2:0] code);
      dly_ticks = CNT_W'(DLY_US[code] * 1000 / TICK_NS);
   endfunction
endpackage

// *** dif_reg_if.sv ***
// Carrier between the serial port and the register bank
interface dif_reg_if;
   logic frame_ok;
   logic bad_cnt;
   logic wr;
   logic rd;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] di;
   logic [7:0] wb;
   logic [2:0] tail;
   modport port (output frame_ok, bad_cnt, wr, rd, addr, wdata, input rdata, di, wb, tail);
   modport regs (input frame_ok, bad_cnt, wr, rd, addr, wdata, output rdata, di, wb, tail);
endinterface

// *** dif_filter.sv ***
// Debounce filter for one channel with selectable delay, bypass and freeze
module dif_filter
   import dif_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic en,
   input wire logic bypass,
   input wire logic freeze,
   input wire logic [2:0] code,
   input wire logic raw,
   output logic q
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] lim;
   logic q_r;

   assign lim = dly_ticks(code);
   assign q = q_r;

   // Integrating counter, parked at mid-scale while frozen
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else if (!en) begin
         cnt_r <= '0;
      end else if (freeze) begin
         cnt_r <= lim >> 1;
      end else if (tick && raw && cnt_r < lim) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (tick && !raw && cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // Output flips at the ends of the count, or follows the input when bypassed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_r <= 1'b0;
      end else if (!en) begin
         q_r <= 1'b0;
      end else if (bypass) begin
         q_r <= raw;
      end else if (cnt_r >= lim) begin
         q_r <= 1'b1;
      end else if (cnt_r == '0) begin
         q_r <= 1'b0;
      end
   end

   a_bypass_follow: assert property (@(posedge clk) disable iff (reset)
      en && bypass |=> q_r == $past(raw))
      else $error("bypassed filter does not follow its input");
   a_freeze_mid: assert property (@(posedge clk) disable iff (reset)
      en && freeze |=> cnt_r == ($past(lim) >> 1))
      else $error("frozen filter not at mid-scale");
   a_rise_limit: assert property (@(posedge clk) disable iff (reset)
      $rose(q_r) && $past(en) && !$past(bypass) |-> $past(cnt_r) >= $past(lim))
      else $error("filter output rose before the delay ran out");
endmodule

// *** dif_spi_port.sv ***
// Serial port: pin sampling, command capture and status shift-out
module dif_spi_port
   import dif_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic pipe,
   output logic sdo,
   output logic sdo_oe,
   dif_reg_if.port rf
);
   logic [2:0] sck_r;
   logic [1:0] cs_r;
   logic cs_d_r;
   logic [1:0] sdi_r;
   logic [15:0] in_r;
   logic [23:0] out_r;
   logic [5:0] cnt_r;
   logic got_r;
   logic prev_rd_r;
   logic [7:0] held_r;
   logic sel;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;
   logic whole;
   logic [7:0] cmd;

   // Two-stage synchronisers, stage 0 feeds only stage 1
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sck_r <= 3'h0;
         cs_r <= 2'h3;
         cs_d_r <= 1'b1;
         sdi_r <= 2'h0;
      end else begin
         sck_r <= {sck_r[1:0], sclk};
         cs_r <= {cs_r[0], cs_n};
         cs_d_r <= cs_r[1];
         sdi_r <= {sdi_r[0], sdi};
      end
   end

   assign sel = !cs_r[1];
   assign rise = sel && sck_r[1] && !sck_r[2];
   assign fall = sel && !sck_r[1] && sck_r[2];
   assign cs_fall = sel && cs_d_r;
   assign cs_rise = cs_r[1] && !cs_d_r;
   assign whole = cnt_r[2:0] == 3'h0;
   assign cmd = got_r ? in_r[15:8] : in_r[7:0];
   assign rf.addr = cmd[6:0];
   assign rf.wdata = in_r[7:0];
   assign sdo = out_r[23];
   assign sdo_oe = sel;

   // Bit counter and command capture on clock rising edges
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         in_r <= 16'h0000;
         cnt_r <= 6'h00;
         got_r <= 1'b0;
      end else if (cs_fall) begin
         cnt_r <= 6'h00;
         got_r <= 1'b0;
      end else if (rise) begin
         cnt_r <= cnt_r + 1'b1;
         if (!got_r) begin
            in_r <= {in_r[14:0], sdi_r[1]};
         end
         if (cnt_r == 6'(FRAME_CMD - 1)) begin
            got_r <= 1'b1;
         end
      end
   end

   // Status shifts out on falling edges; read data replaces the second byte
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_r <= 24'h000000;
      end else if (cs_fall) begin
         out_r <= {rf.di, (pipe && prev_rd_r) ? held_r : rf.wb, rf.tail, 5'h00};
      end else if (fall && cnt_r == 6'h08 && !got_r && !pipe && !cmd[7]) begin
         out_r <= {rf.rdata, out_r[14:0], 1'b0};
      end else if (fall) begin
         out_r <= {out_r[22:0], 1'b0};
      end
   end

   // Frame end: accept whole-byte frames of 16 bits or more, reject partial bytes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rf.frame_ok <= 1'b0;
         rf.bad_cnt <= 1'b0;
         rf.wr <= 1'b0;
         rf.rd <= 1'b0;
         prev_rd_r <= 1'b0;
         held_r <= 8'h00;
      end else begin
         rf.frame_ok <= cs_rise && whole && got_r;
         rf.bad_cnt <= cs_rise && !whole;
         rf.wr <= cs_rise && whole && got_r && cmd[7];
         rf.rd <= cs_rise && whole && got_r && !cmd[7];
         if (cs_rise && whole && got_r) begin
            prev_rd_r <= !cmd[7];
            held_r <= rf.rdata;
         end
      end
   end
endmodule

// *** dif_top.sv ***
// Register bank, fault logic and channel filters of the digital input block
// What this block does
// - Bypass bit routes the channel around its debounce filter, else filter applies.
// - Three-bit delay code picks 50us to 20ms filter delay.
// - Wire-break filters always use a fixed 20ms delay.
// - In modes 0 and 2, supply flags also clear per frame unless policy set.
// - Freeze holds every enabled filter at mid-scale count; clearing resumes filtering.
// - Config bit 0 enables current reference short detection.
// - Disabled channel sources no current and reads zero; all enabled after reset.
// - Clock count not a multiple of eight rejects the frame and flags it.
// - Overtemperature sets its flag and turns off inputs and LEDs; serial stays alive.
// - Current reference open, or thermal shutdown, latches a flag until read.
// - Current reference short latches a flag; channels off while the short lasts.
// - Wire reference open latches on open pin, shutdown, or all detection off.
// - Wire reference short latches until read, no effect on channels.
// - Detail enables let detail flags set the summary bit; all off after reset.
// - Non-sticky fault pin follows the unmasked live sources and the latched CRC, POR and detail flags.
// - Sticky fault pin stays low until the primary register is read.
// - Mask bits gate primary flags onto the fault pin; reset value 0xc0.
// - Fault pin is active low.
// - Writes to the dummy register change no settings; status still shifts out.
// - Channel one sits at bit 0, channel eight at bit 7.
// - Summary bit clears on read only once its enabled sources are gone.
// - Wire-break enable bit gates detection; flag stays low when clear.
module dif_top
   import dif_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic mode0,
   input wire logic mode1,
   input wire logic [7:0] in_raw,
   input wire logic [7:0] wb_raw,
   input wire logic ref_di_open,
   input wire logic ref_di_short,
   input wire logic ref_wb_open,
   input wire logic ref_wb_short,
   input wire logic overtemp,
   input wire logic temp_alarm_one,
   input wire logic temp_alarm_two,
   input wire logic supply_low,
   input wire logic supply_missing,
   input wire logic crc_mismatch,
   output logic sdo,
   output logic sdo_oe,
   output logic [7:0] cur_src_en,
   output logic [7:0] led_en,
   output logic [7:0] wb_det_en,
   output logic ref_short_det_en,
   output logic [7:0] input_state_bits,
   output logic fault_n
);
   dif_reg_if rf ();

   logic [NASYNC-1:0] sa_r;
   logic [NASYNC-1:0] sb_r;
   logic [7:0] in_s;
   logic [7:0] wb_s;
   logic crc_mode;
   logic pipe;
   logic rdo_s;
   logic rds_s;
   logic rwo_s;
   logic rws_s;
   logic ot_s;
   logic at1_s;
   logic at2_s;
   logic svl_s;
   logic svm_s;
   logic [15:0] div_r;
   logic tick_r;
   logic [4:0] flt_r [NCH];
   logic [7:0] cfg_r;
   logic [7:0] en_r;
   logic [5:0] f2en_r;
   logic stk_r;
   logic [7:0] f1en_r;
   logic [7:0] f1_r;
   logic [7:0] f1_nxt;
   logic [5:0] f2_r;
   logic [5:0] f2_nxt;
   logic [5:0] f2_set;
   logic [7:0] wb_r;
   logic [7:0] wb_set;
   logic [7:0] di_r;
   logic [7:0] in_q;
   logic [7:0] wb_q;
   logic [7:0] act;
   logic [7:0] wire_break_enable;
   logic [7:0] rt;
   logic [7:0] rdata;
   logic rds_live;
   logic hold_r;
   logic hold_nxt;
   logic fault_r;
   logic rd_f1;
   logic rd_f2;
   logic rd_wb;
   logic sup_clr;

   // True for a filter setup address
   function automatic logic flt_hit(input logic [6:0] a);
      flt_hit = a >= A_FLT0 && a <= A_FLT7 && !a[0];
   endfunction

   // Channel index of a filter setup address
   function automatic logic [2:0] flt_idx(input logic [6:0] a);
      logic [6:0] d;
      d = a - A_FLT0;
      flt_idx = d[3:1];
   endfunction

   // Two-stage synchroniser for pins and analog comparator outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sa_r <= '0;
         sb_r <= '0;
      end else begin
         sa_r <= {in_raw, wb_raw, mode1, mode0, ref_di_open, ref_di_short,
                  ref_wb_open, ref_wb_short, overtemp, temp_alarm_one,
                  temp_alarm_two, supply_low, supply_missing};
         sb_r <= sa_r;
      end
   end

   assign in_s = sb_r[26:19];
   assign wb_s = sb_r[18:11];
   assign pipe = sb_r[10];
   assign crc_mode = !sb_r[9];
   assign rdo_s = sb_r[8];
   assign rds_s = sb_r[7];
   assign rwo_s = sb_r[6];
   assign rws_s = sb_r[5];
   assign ot_s = sb_r[4];
   assign at1_s = sb_r[3];
   assign at2_s = sb_r[2];
   assign svl_s = sb_r[1];
   assign svm_s = sb_r[0];

   // Filter time base divider
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (div_r == 16'(TICK_CYCLES - 1)) begin
         div_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // Channel gating: a live reference short or shutdown turns inputs off
   assign rds_live = rds_s && cfg_r[CFG_SHE];
   assign act = en_r & ~{8{ot_s | rds_live}};

   // Per-channel input and wire-break filters, channel one at bit 0
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign wire_break_enable[i] = flt_r[i][FLT_WBE];
      dif_filter u_in (
         .clk(clk),
         .reset(reset),
         .tick(tick_r),
         .en(act[i]),
         .bypass(flt_r[i][FLT_BYP]),
         .freeze(cfg_r[CFG_FRZ]),
         .code(flt_r[i][2:0]),
         .raw(in_s[i]),
         .q(in_q[i])
      );
      dif_filter u_wb (
         .clk(clk),
         .reset(reset),
         .tick(tick_r),
         .en(act[i] && wire_break_enable[i]),
         .bypass(1'b0),
         .freeze(cfg_r[CFG_FRZ]),
         .code(WB_CODE),
         .raw(wb_s[i]),
         .q(wb_q[i])
      );
   end

   dif_spi_port u_spi (
      .clk(clk),
      .reset(reset),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .pipe(pipe),
      .sdo(sdo),
      .sdo_oe(sdo_oe),
      .rf(rf)
   );

   // Read strobes of the clear-on-read registers
   assign rd_f1 = rf.rd && rf.addr == A_F1;
   assign rd_f2 = rf.rd && rf.addr == A_F2;
   assign rd_wb = rf.rd && rf.addr == A_WB;
   assign sup_clr = rf.frame_ok && crc_mode && !cfg_r[CFG_SUP];

   // Configuration writes; unmapped and dummy addresses are dropped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NCH; i++) begin
            flt_r[i] <= RST_FLT;
         end
         cfg_r <= RST_CFG;
         en_r <= RST_EN;
         f2en_r <= RST_F2EN;
         stk_r <= 1'b0;
         f1en_r <= RST_F1EN;
      end else if (rf.wr) begin
         case (rf.addr)
            A_CFG: cfg_r <= rf.wdata & CFG_WMASK;
            A_EN: en_r <= rf.wdata;
            A_F2EN: f2en_r <= rf.wdata[5:0];
            A_GPO: stk_r <= rf.wdata[GPO_STK];
            A_F1EN: f1en_r <= rf.wdata;
            default: begin
               if (flt_hit(rf.addr)) begin
                  flt_r[flt_idx(rf.addr)] <= rf.wdata[4:0];
               end
            end
         endcase
      end
   end

   // Wire-break flags latch and clear on read unless still present
   assign wb_set = wb_q & wire_break_enable & act;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_r <= 8'h00;
      end else begin
         wb_r <= wb_set | (wb_r & ~{8{rd_wb}});
      end
   end

   // Detail fault sources; a set in the read cycle wins over the clear
   assign f2_set[F2_CLK] = rf.bad_cnt;
   assign f2_set[F2_OT] = ot_s;
   assign f2_set[F2_RDO] = rdo_s | ot_s;
   assign f2_set[F2_RDS] = rds_live;
   assign f2_set[F2_RWO] = rwo_s | ot_s | (wire_break_enable == 8'h00);
   assign f2_set[F2_RWS] = rws_s;
   assign f2_nxt = f2_set | (f2_r & ~{6{rd_f2}});

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         f2_r <= RST_F2;
      end else begin
         f2_r <= f2_nxt;
      end
   end

   // Primary fault register: clears first, sets last so sets win
   always_comb begin
      f1_nxt = f1_r;
      if (rd_f1) begin
         f1_nxt = f1_r & F1_KEEP_RD;
      end
      if (sup_clr) begin
         f1_nxt[F1_SVL] = 1'b0;
         f1_nxt[F1_SVM] = 1'b0;
      end
      if (rf.wr && rf.addr == A_F1 && !rf.wdata[F1_POR]) begin
         f1_nxt[F1_POR] = 1'b0;
      end
      if (rd_wb) begin
         f1_nxt[F1_WBG] = 1'b0;
      end
      if (rf.frame_ok && crc_mode) begin
         f1_nxt[F1_CRC] = crc_mismatch;
      end
      f1_nxt[F1_SUM] = f1_nxt[F1_SUM] | (|(f2_r & f2en_r));
      f1_nxt[F1_AT2] = f1_nxt[F1_AT2] | at2_s;
      f1_nxt[F1_AT1] = f1_nxt[F1_AT1] | at1_s;
      f1_nxt[F1_SVL] = f1_nxt[F1_SVL] | svl_s;
      f1_nxt[F1_SVM] = f1_nxt[F1_SVM] | svm_s;
      f1_nxt[F1_WBG] = f1_nxt[F1_WBG] | (|wb_set);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         f1_r <= RST_F1;
      end else begin
         f1_r <= f1_nxt;
      end
   end

   // Fault sources as seen by the non-sticky pin; CRC, POR and detail flags are latched
   assign rt = {f1_r[F1_CRC], f1_r[F1_POR], |(f2_r & f2en_r), at2_s, at1_s,
                svl_s, svm_s, |wb_set};
   assign hold_nxt = (|(f1_nxt & f1en_r)) | (hold_r & !rd_f1);

   // Fault pin drive, masked sources only, low when asserted
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
         if (stk_r) begin
            fault_r <= hold_nxt;
         end else begin
            fault_r <= |(rt & f1en_r);
         end
      end
   end
   assign fault_n = !fault_r;

   // Registered pin outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         di_r <= 8'h00;
         cur_src_en <= 8'h00;
         led_en <= 8'h00;
         wb_det_en <= 8'h00;
         ref_short_det_en <= 1'b0;
      end else begin
         di_r <= in_q & act;
         cur_src_en <= act;
         led_en <= in_q & act & ~{8{ot_s}};
         wb_det_en <= wire_break_enable & act;
         ref_short_det_en <= cfg_r[CFG_SHE];
      end
   end
   assign input_state_bits = di_r;

   // Register read mux; unmapped and reserved bits read as zero
   always_comb begin
      rdata = 8'h00;
      case (rf.addr)
         A_WB: rdata = wb_r;
         A_DI: rdata = di_r;
         A_F1: rdata = f1_r;
         A_CFG: rdata = cfg_r;
         A_EN: rdata = en_r;
         A_F2: rdata = {2'b00, f2_r};
         A_F2EN: rdata = {2'b00, f2en_r};
         A_GPO: rdata = {stk_r, 7'h00};
         A_F1EN: rdata = f1en_r;
         default: begin
            if (flt_hit(rf.addr)) begin
               rdata = {3'b000, flt_r[flt_idx(rf.addr)]};
            end
         end
      endcase
   end
   assign rf.rdata = rdata;
   assign rf.di = di_r;
   assign rf.wb = wb_r;
   assign rf.tail = f1_r[2:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_chan_off: assert property (
      ##1 (cur_src_en & ~$past(en_r)) == 8'h00)
      else $error("disabled channel still sources current");
   a_bad_count: assert property (
      rf.bad_cnt |=> f2_r[F2_CLK] && !rf.wr)
      else $error("bad clock count not flagged");
   a_ot_off: assert property (
      ot_s |=> cur_src_en == 8'h00 && led_en == 8'h00 && f2_r[F2_OT])
      else $error("inputs not off in thermal shutdown");
   a_short_off: assert property (
      rds_live |=> cur_src_en == 8'h00 && f2_r[F2_RDS])
      else $error("channels live during reference short");
   a_f2_latch: assert property (
      f2_r[F2_RDO] && !rd_f2 |=> f2_r[F2_RDO])
      else $error("reference open flag lost before read");
   a_sum_set: assert property (
      |(f2_r & f2en_r) |=> f1_r[F1_SUM])
      else $error("enabled detail flag did not set summary");
   a_supply_keep: assert property (
      rf.frame_ok && cfg_r[CFG_SUP] && !rd_f1 && f1_r[F1_SVL] |=> f1_r[F1_SVL])
      else $error("supply flag cleared by frame under read-only policy");
   a_sticky_pin: assert property (
      stk_r && hold_r && !rd_f1 |=> !fault_n)
      else $error("sticky fault pin released without read");
   a_live_pin: assert property (
      !stk_r |=> fault_n == !$past(|(rt & f1en_r)))
      else $error("non-sticky fault pin does not track sources");
   a_nop_write: assert property (
      rf.wr && rf.addr == A_NOP |=> $stable(cfg_r) && $stable(en_r) && $stable(f1en_r))
      else $error("dummy write changed state");
   a_reserved_zero: assert property (
      (cfg_r & ~CFG_WMASK) == 8'h00 && (rf.addr != A_GPO || rdata[6:0] == 7'h00))
      else $error("reserved config bits set");

   c_sticky: cover property (stk_r && !fault_n ##1 rd_f1);
   c_bad_frame: cover property (rf.bad_cnt);
   c_freeze: cover property (cfg_r[CFG_FRZ] && tick_r);
   c_read_f1: cover property (rd_f1 && f1_r[F1_SUM]);
endmodule

// *** dif_spi_host.sv ***
// Serial host model that sends command frames and collects the returned bits
module dif_spi_host (
   input wire logic clk,
   input wire logic sdo,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // Frame of n bits, MSB first, 8 clk per bit; data read once the rise is settled
   task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      repeat (3) @(posedge clk);
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b0;
         sdi <= cmd[15-i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         @(negedge clk) rx = {rx[14:0], sdo};
         repeat (4) @(posedge clk);
      end
      sclk <= 1'b0;
      sdi <= ~sdi; // Released line shows no stale value
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
endmodule

// *** dif_top_tb_top.sv ***
// Bench for the digital input fault and configuration block
module dif_top_tb_top;
   import dif_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 2;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ovt = 1'b0;
   logic sl = 1'b0;
   logic mode0 = 1'b1;
   logic rsh = 1'b0;
   logic sclk, cs_n, sdi, sdo, fault_n, rsd, soe;
   logic [7:0] in_raw, cse, led, isb, wde;
   logic [15:0] rx;
   int mismatches = 0;
   int total_checks = 0;
   int rm[int] = '{A_FLT0: 8'h08, A_CFG: 8'h00, A_EN: 8'hff, A_F2EN: 8'h00, A_GPO: 8'h00,
      A_F1EN: 8'hc0};
   int rs[int];
   int wm[int] = '{A_FLT0: 8'h1f, A_CFG: 8'h19, A_EN: 8'hff, A_F2EN: 8'h3f, A_GPO: 8'h80,
      A_F1EN: 8'hff};
   always #25 clk = ~clk;
   dif_spi_host m (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   dif_top #(.TICK_CYCLES(TC)) uut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .mode0(mode0), .mode1(1'b0), .in_raw(in_raw), .wb_raw(8'h00),
      .ref_di_open(ovt), .ref_di_short(rsh), .ref_wb_open(ovt), .ref_wb_short(ovt),
      .overtemp(ovt), .temp_alarm_one(ovt), .temp_alarm_two(ovt), .supply_low(sl),
      .supply_missing(sl), .crc_mismatch(1'b0), .sdo(sdo), .sdo_oe(soe), .cur_src_en(cse),
      .led_en(led), .wb_det_en(wde), .ref_short_det_en(rsd), .input_state_bits(isb),
      .fault_n(fault_n));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Compare one value against the model
   task automatic chk(input string nm, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Write a register; the model keeps only writable bits
   task automatic wr(input int a, input logic [7:0] d);
      m.xfer({1'b1, 7'(a), d}, 16, rx);
      chk("di", rx[15:8], in_raw & 8'(rm[A_EN]));
      if (rm.exists(a)) rm[a] = d & wm[a];
   endtask
   task automatic rd(input int a, input logic [7:0] e);
      m.xfer({1'b0, 7'(a), 8'h00}, 16, rx);
      chk("di", rx[15:8], in_raw & 8'(rm[A_EN]));
      chk("reg", rx[7:0], e);
   endtask
   // Bounded wait for the fault pin level
   task automatic wf(input logic v);
      for (int i = 0; i < 20 && fault_n !== v; i++) @(negedge clk);
      chk("fault_n", {7'h00, fault_n}, {7'h00, v});
      if (fault_n !== v) finish_test();
   endtask
   initial begin
      void'($urandom(32'hcc4611d3));
      in_raw <= 8'($urandom) & 8'hfe;
      rs = rm;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      wf(1'b0);
      foreach (rm[a]) rd(a, 8'(rm[a]));
      m.xfer({1'b1, A_CFG, 8'h08}, 12, rx);
      rd(A_F2, 8'h22);
      rd(A_F2, 8'h02);
      rd(A_CFG, 8'h00);
      foreach (rm[a]) begin
         wr(a, 8'hff);
         rd(a, 8'(rm[a]));
      end
      chk("ref_short_en", {7'h00, rsd}, 8'h01);
      chk("wb_det", wde, 8'h01);
      foreach (rs[a]) wr(a, 8'(rs[a]));
      chk("ref_short_en", {7'h00, rsd}, 8'h00);
      chk("wb_det", wde, 8'h00);
      wr(A_EN, 8'($urandom) | 8'h01);
      chk("cur_src", cse, 8'(rm[A_EN]));
      chk("inputs", isb, in_raw & 8'(rm[A_EN]));
      wr(A_NOP, 8'h00);
      chk("sdo_oe", {7'h00, soe}, 8'h00);
      rd(A_EN, 8'(rm[A_EN]));
      wr(A_EN, 8'hff);
      @(posedge clk) ovt <= 1'b1;
      repeat (10) @(posedge clk);
      chk("cur_src", cse, 8'h00);
      chk("led", led, 8'h00);
      @(posedge clk) ovt <= 1'b0;
      repeat (6) @(posedge clk);
      rd(A_F2, 8'h1b);
      rd(A_F2, 8'h02);
      wr(A_F1, 8'h00);
      wf(1'b1);
      wr(A_F1EN, 8'h04);
      @(posedge clk) sl <= 1'b1;
      wf(1'b0);
      @(posedge clk) sl <= 1'b0;
      wf(1'b1);
      wr(A_GPO, 8'h80);
      wf(1'b0);
      repeat (20) @(posedge clk);
      chk("fault_n", {7'h00, fault_n}, 8'h00);
      rd(A_F1, 8'h3e);
      wf(1'b1);
      rd(A_F1, 8'h00);
      // Mode 0: supply flags clear per frame, then only on read under policy
      mode0 <= 1'b0;
      sl <= 1'b1;
      repeat (4) @(posedge clk);
      sl <= 1'b0;
      wr(A_NOP, 8'h00);
      rd(A_F1, 8'h00);
      wr(A_CFG, 8'h11);
      sl <= 1'b1;
      repeat (4) @(posedge clk);
      sl <= 1'b0;
      wr(A_NOP, 8'h00);
      rd(A_F1, 8'h06);
      // Host masks the supply flags when running without field supply
      wr(A_F1EN, 8'hc0);
      sl <= 1'b1;
      repeat (6) @(posedge clk);
      wf(1'b1);
      // Live reference short turns every channel off and latches its flag
      rsh <= 1'b1;
      repeat (6) @(posedge clk);
      chk("cur_src", cse, 8'h00);
      rsh <= 1'b0;
      rd(A_F2, 8'h06);
      wr(A_FLT0, 8'h00);
      repeat (40) @(posedge clk);
      in_raw[0] <= 1'b1;
      repeat (TC * 5 - 4) @(posedge clk);
      chk("filter", isb & 8'h01, 8'h00);
      repeat (TC * 5 + 10) @(posedge clk);
      chk("filter", isb & 8'h01, 8'h01);
      finish_test();
   end
endmodule
